// ==== peripheral_irq_flag_enable_priority.sv ====
// Local design decisions: the Wishbone slave port and the register addresses.
`default_nettype none
module peripheral_irq_flag_enable_priority
  import irq_bank_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  input wire logic [7:0] group1_flags_i,
  input wire logic parallel_port_active_i,
  input wire group2_events_s group2_events_i,
  input wire group3_events_s group3_events_i,
  output logic irq_high_o,
  output logic irq_low_o
);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] read_mux;
  logic wr_commit;
  logic wr_flags2;
  logic wr_flags3;
  logic wr_enable1;
  logic wr_enable2;
  logic wr_enable3;
  logic wr_priority1;
  logic wr_control;

  logic [7:0] flags2_q;
  logic [7:0] flags2_d;
  logic [7:0] flags3_q;
  logic [7:0] flags3_d;
  logic [7:0] enable1_q;
  logic [7:0] enable1_d;
  logic [7:0] enable2_q;
  logic [7:0] enable2_d;
  logic [7:0] enable3_q;
  logic [7:0] enable3_d;
  logic [7:0] priority1_q;
  logic [7:0] priority1_d;
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic cmp_prev_q;
  logic cmp_prev_d;
  logic cmp_armed_q;
  logic cmp_armed_d;
  logic irq_high_q;
  logic irq_high_d;
  logic irq_low_q;
  logic irq_low_d;
  logic [7:0] psp_gate;

  assign wr_commit = cyc_i && stb_i && we_i && ack_q && sel_i[0];
  assign wr_flags2 = wr_commit && (adr_i == OFS_FLAGS2);
  assign wr_flags3 = wr_commit && (adr_i == OFS_FLAGS3);
  assign wr_enable1 = wr_commit && (adr_i == OFS_ENABLE1);
  assign wr_enable2 = wr_commit && (adr_i == OFS_ENABLE2);
  assign wr_enable3 = wr_commit && (adr_i == OFS_ENABLE3);
  assign wr_priority1 = wr_commit && (adr_i == OFS_PRIORITY1);
  assign wr_control = wr_commit && (adr_i == OFS_CONTROL);

  // parallel port bits only count in microcontroller mode
  assign psp_gate = parallel_port_active_i ? 8'hFF : ~MASK_PARALLEL;

  always_comb
  begin
    unique case (adr_i)
      OFS_FLAGS2: read_mux = flags2_q & MASK_GROUP2;
      OFS_FLAGS3: read_mux = flags3_q & MASK_GROUP3;
      OFS_ENABLE1: read_mux = enable1_q;
      OFS_ENABLE2: read_mux = enable2_q & MASK_GROUP2;
      OFS_ENABLE3: read_mux = enable3_q & MASK_GROUP3;
      OFS_PRIORITY1: read_mux = priority1_q;
      OFS_CONTROL: read_mux = control_q;
      OFS_STATUS: read_mux = {6'h00, irq_high_q, irq_low_q};
      default: read_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    ack_d = cyc_i && stb_i && !ack_q;
    rdata_d = rdata_q;
    if (ack_d)
    begin
      rdata_d = we_i ? RST_RDATA : {PAD_ZERO, read_mux};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= RST_RDATA;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // request flags
  always_comb
  begin
    logic [7:0] set2;
    logic [7:0] set3;
    logic [7:0] base2;
    logic [7:0] base3;
    set2 = 8'h00;
    set3 = 8'h00;
    base2 = wr_flags2 ? dat_i[7:0] : flags2_q;
    base3 = wr_flags3 ? dat_i[7:0] : flags3_q;
    cmp_prev_d = group2_events_i.cmp_level;
    // no compare in the first cycle after reset, so a high input is no change
    cmp_armed_d = 1'b1;
    // flags set regardless of enables; set wins over a clearing write
    set2[B_CMP] = cmp_armed_q && (group2_events_i.cmp_level != cmp_prev_q);
    set2[B_NVM] = group2_events_i.nvm_done;
    set2[B_BCL] = group2_events_i.bus_collision;
    set2[B_LVD] = group2_events_i.low_voltage;
    set2[B_TMR3] = group2_events_i.timer3_overflow;
    set2[B_CCP2] = group2_events_i.capcmp2_event && !group2_events_i.capcmp2_pwm;
    set3[B_TMR4] = group3_events_i.timer4_event;
    set3[2:0] = group3_events_i.capcmp345_event & ~group3_events_i.capcmp345_pwm;
    flags2_d = (base2 | set2) & MASK_GROUP2;
    if (group2_events_i.nvm_busy)
    begin
      flags2_d[B_NVM] = 1'b0;
    end
    flags3_d = (base3 | set3) & MASK_GROUP3_SW;
    flags3_d[B_RX2] = group3_events_i.rx_full;
    flags3_d[B_TX2] = group3_events_i.tx_empty;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags2_q <= RST_FLAGS;
      flags3_q <= RST_FLAGS;
      cmp_prev_q <= 1'b0;
      cmp_armed_q <= 1'b0;
    end
    else
    begin
      flags2_q <= flags2_d;
      flags3_q <= flags3_d;
      cmp_prev_q <= cmp_prev_d;
      cmp_armed_q <= cmp_armed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables, priority, control
  always_comb
  begin
    enable1_d = wr_enable1 ? dat_i[7:0] : enable1_q;
    enable2_d = wr_enable2 ? (dat_i[7:0] & MASK_GROUP2) : enable2_q;
    enable3_d = wr_enable3 ? (dat_i[7:0] & MASK_GROUP3) : enable3_q;
    priority1_d = wr_priority1 ? dat_i[7:0] : priority1_q;
    control_d = wr_control ? (dat_i[7:0] & MASK_CONTROL) : control_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable1_q <= RST_ENABLE;
      enable2_q <= RST_ENABLE;
      enable3_q <= RST_ENABLE;
      priority1_q <= RST_PRIORITY1;
      control_q <= RST_CONTROL;
    end
    else
    begin
      enable1_q <= enable1_d;
      enable2_q <= enable2_d;
      enable3_q <= enable3_d;
      priority1_q <= priority1_d;
      control_q <= control_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request steering to the core
  always_comb
  begin
    logic [7:0] pend1;
    logic pend_rest;
    logic pend_any;
    pend1 = group1_flags_i & enable1_q & psp_gate;
    pend_rest = |(flags2_q & enable2_q) || |(flags3_q & enable3_q);
    pend_any = |pend1 || pend_rest;
    if (control_q[B_PLE])
    begin
      // groups two and three steer to the high class
      irq_high_d = |(pend1 & priority1_q) || pend_rest;
      irq_low_d = |(pend1 & ~priority1_q);
    end
    else
    begin
      // single class, priority bits ignored
      irq_high_d = control_q[B_PGE] && pend_any;
      irq_low_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_high_q <= 1'b0;
      irq_low_q <= 1'b0;
    end
    else
    begin
      irq_high_q <= irq_high_d;
      irq_low_q <= irq_low_d;
    end
  end

  assign irq_high_o = irq_high_q;
  assign irq_low_o = irq_low_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  cmp_flag_set_a: assert property (
    (cmp_armed_q && group2_events_i.cmp_level != cmp_prev_q) |=> flags2_q[B_CMP])
    else $error("comparator change did not set flag");

  cmp_no_false_a: assert property (
    (!cmp_armed_q && !flags2_q[B_CMP] && !wr_flags2) |=> !flags2_q[B_CMP])
    else $error("comparator flag set without a change");

  nvm_pending_zero_a: assert property (
    group2_events_i.nvm_busy |=> !flags2_q[B_NVM])
    else $error("nvm flag high while write pending");

  bcl_sticky_a: assert property (
    (flags2_q[B_BCL] && !wr_flags2) |=> flags2_q[B_BCL])
    else $error("bus collision flag cleared without write");

  lvd_set_a: assert property (
    group2_events_i.low_voltage |=> flags2_q[B_LVD])
    else $error("low voltage did not set flag");

  rx_follow_a: assert property (
    1'b1 |=> flags3_q[B_RX2] == $past(group3_events_i.rx_full))
    else $error("rx flag does not follow buffer");

  unimpl_zero_a: assert property (
    (flags2_q & ~MASK_GROUP2) == 8'h00 && (flags3_q & ~MASK_GROUP3) == 8'h00
    && (enable2_q & ~MASK_GROUP2) == 8'h00 && (enable3_q & ~MASK_GROUP3) == 8'h00)
    else $error("unimplemented bit set");

  timer4_set_a: assert property (
    group3_events_i.timer4_event |=> flags3_q[B_TMR4])
    else $error("timer4 event did not set flag");

  no_low_class_a: assert property (
    !control_q[B_PLE] |=> !irq_low_o)
    else $error("low request without priority levels");

  group_gate_a: assert property (
    (!control_q[B_PLE] && !control_q[B_PGE]) |=> !irq_high_o)
    else $error("request without group enable");

  nvm_done_set_a: assert property (
    (group2_events_i.nvm_done && !group2_events_i.nvm_busy) |=> flags2_q[B_NVM])
    else $error("nvm write done did not set flag");

  bcl_set_a: assert property (
    group2_events_i.bus_collision |=> flags2_q[B_BCL])
    else $error("bus collision did not set flag");

  lvd_sticky_a: assert property (
    (flags2_q[B_LVD] && !wr_flags2) |=> flags2_q[B_LVD])
    else $error("low voltage flag cleared without write");

  tmr3_set_a: assert property (
    group2_events_i.timer3_overflow |=> flags2_q[B_TMR3])
    else $error("timer3 overflow did not set flag");

  ccp2_set_a: assert property (
    (group2_events_i.capcmp2_event && !group2_events_i.capcmp2_pwm) |=> flags2_q[B_CCP2])
    else $error("capcmp2 event did not set flag");

  ccp2_pwm_a: assert property (
    (group2_events_i.capcmp2_pwm && !flags2_q[B_CCP2] && !wr_flags2) |=> !flags2_q[B_CCP2])
    else $error("capcmp2 flag set in pwm mode");

  tx_follow_a: assert property (
    1'b1 |=> flags3_q[B_TX2] == $past(group3_events_i.tx_empty))
    else $error("tx flag does not follow buffer");

  ccp345_set_a: assert property (
    1'b1 |=> &(flags3_q[2:0] | ~$past(group3_events_i.capcmp345_event)
    | $past(group3_events_i.capcmp345_pwm)))
    else $error("capcmp3..5 event did not set flag");

  enable1_write_a: assert property (
    wr_enable1 |=> enable1_q == $past(dat_i[7:0]))
    else $error("enable1 write did not land");

  enable_gate_a: assert property (
    ((group1_flags_i & enable1_q & psp_gate) == 8'h00 && (flags2_q & enable2_q) == 8'h00
    && (flags3_q & enable3_q) == 8'h00) |=> !irq_high_o && !irq_low_o)
    else $error("request from a disabled source");

  psp_off_a: assert property (
    (!parallel_port_active_i && (group1_flags_i & enable1_q & ~MASK_PARALLEL) == 8'h00
    && (flags2_q & enable2_q) == 8'h00 && (flags3_q & enable3_q) == 8'h00)
    |=> !irq_high_o && !irq_low_o)
    else $error("parallel port request outside microcontroller mode");

  single_class_a: assert property (
    (!control_q[B_PLE] && control_q[B_PGE] && |(group1_flags_i & enable1_q & ~MASK_PARALLEL))
    |=> irq_high_o)
    else $error("enabled request missing in single class");

  high_class_a: assert property (
    (control_q[B_PLE] && |(group1_flags_i & enable1_q & priority1_q & ~MASK_PARALLEL))
    |=> irq_high_o)
    else $error("high priority source not on high request");

  low_class_a: assert property (
    (control_q[B_PLE] && |(group1_flags_i & enable1_q & ~priority1_q & ~MASK_PARALLEL))
    |=> irq_low_o)
    else $error("low priority source not on low request");

  ack_pulse_a: assert property (
    ack_o |=> !ack_o)
    else $error("ack held more than one cycle");

  flag_write_c: cover property (wr_flags2);
  high_req_c: cover property (!irq_high_o ##1 irq_high_o);
  low_req_c: cover property (!irq_low_o ##1 irq_low_o);
  read_status_c: cover property (ack_o && !we_i && adr_i == OFS_STATUS);
  pwm_refused_c: cover property (group2_events_i.capcmp2_event && group2_events_i.capcmp2_pwm);

endmodule : peripheral_irq_flag_enable_priority
`default_nettype wire

// ==== irq_bank_pkg.sv ====
`default_nettype none
package irq_bank_pkg;
  localparam logic [7:0] OFS_FLAGS2 = 8'h00;
  localparam logic [7:0] OFS_FLAGS3 = 8'h04;
  localparam logic [7:0] OFS_ENABLE1 = 8'h08;
  localparam logic [7:0] OFS_ENABLE2 = 8'h0C;
  localparam logic [7:0] OFS_ENABLE3 = 8'h10;
  localparam logic [7:0] OFS_PRIORITY1 = 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  localparam logic [7:0] MASK_GROUP2 = 8'h5F;
  localparam logic [7:0] MASK_GROUP3 = 8'h3F;
  localparam logic [7:0] MASK_GROUP3_SW = 8'h0F;
  localparam logic [7:0] MASK_CONTROL = 8'hC0;
  localparam logic [7:0] MASK_PARALLEL = 8'h80;

  localparam int B_CMP = 6;
  localparam int B_NVM = 4;
  localparam int B_BCL = 3;
  localparam int B_LVD = 2;
  localparam int B_TMR3 = 1;
  localparam int B_CCP2 = 0;
  localparam int B_RX2 = 5;
  localparam int B_TX2 = 4;
  localparam int B_TMR4 = 3;
  localparam int B_PLE = 7;
  localparam int B_PGE = 6;

  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PRIORITY1 = 8'hFF;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic [23:0] PAD_ZERO = 24'h00_0000;

  typedef struct packed {
    logic cmp_level;
    logic nvm_busy;
    logic nvm_done;
    logic bus_collision;
    logic low_voltage;
    logic timer3_overflow;
    logic capcmp2_event;
    logic capcmp2_pwm;
  } group2_events_s;

  typedef struct packed {
    logic rx_full;
    logic tx_empty;
    logic timer4_event;
    logic [2:0] capcmp345_event;
    logic [2:0] capcmp345_pwm;
  } group3_events_s;
endpackage : irq_bank_pkg
`default_nettype wire

// ==== event_sources.sv ====
`default_nettype none
module event_sources
  import irq_bank_pkg::*;
(
  input wire logic clk_i,
  output group2_events_s g2_o,
  output group3_events_s g3_o,
  output logic [7:0] g1_o,
  output logic pp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////
  initial
  begin
    g2_o = '0;
    g3_o = '0;
    g1_o = 8'h00;
    pp_o = 1'b0;
  end
  // sources change just after an edge and hold until the next call
  task automatic put(input logic [7:0] e2, input logic [8:0] e3, input logic [7:0] f1,
                     input logic pp);
    @(posedge clk_i);
    g2_o <= group2_events_s'(e2);
    g3_o <= group3_events_s'(e3);
    g1_o <= f1;
    pp_o <= pp;
  endtask : put
endmodule : event_sources
`default_nettype wire

// ==== peripheral_irq_flag_enable_priority_tb.sv ====
`default_nettype none
module peripheral_irq_flag_enable_priority_tb
  import irq_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_high_o, irq_low_o, pp;
  logic [7:0] adr_i, g1;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, q;
  group2_events_s g2;
  group3_events_s g3;
  int n_fail, checks;
  logic [7:0] ofs [7];
  logic [7:0] rv [7];
  ////////////////////////////////////////////////////////////////
  peripheral_irq_flag_enable_priority dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i), .ack_o(ack_o),
    .dat_o(dat_o), .group1_flags_i(g1), .parallel_port_active_i(pp), .group2_events_i(g2),
    .group3_events_i(g3), .irq_high_o(irq_high_o), .irq_low_o(irq_low_o));
  event_sources src (.clk_i(clk_i), .g2_o(g2), .g3_o(g3), .g1_o(g1), .pp_o(pp));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {PAD_ZERO, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk(nm, {PAD_ZERO, e}, q);
  endtask : rd
  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    final_report;
  end
  initial
  begin
    n_fail = 0;
    checks = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    sel = 4'hF;
    adr_i = 8'h00;
    dat_i = 32'h0000_0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    ofs = '{OFS_FLAGS2, OFS_FLAGS3, OFS_ENABLE1, OFS_ENABLE2, OFS_ENABLE3, OFS_PRIORITY1,
            OFS_CONTROL};
    rv = '{RST_FLAGS, RST_FLAGS, RST_ENABLE, RST_ENABLE, RST_ENABLE, RST_PRIORITY1, RST_CONTROL};
    foreach (ofs[i])
      rd("reset", ofs[i], rv[i]);
    // second group events with all enables off
    src.put(8'hBE, 9'h000, 8'h00, 1'b0);
    src.put(8'h80, 9'h000, 8'h00, 1'b0);
    rd("flags2", OFS_FLAGS2, 8'h5F);
    wb(OFS_FLAGS2, 1'b1, 8'h00);
    rd("flags2 clr", OFS_FLAGS2, 8'h00);
    src.put(8'hE3, 9'h000, 8'h00, 1'b0);
    src.put(8'h80, 9'h000, 8'h00, 1'b0);
    rd("flags2 busy pwm", OFS_FLAGS2, 8'h00);
    // third group: buffer levels, timer4, units three to five
    src.put(8'h80, 9'h1F8, 8'h00, 1'b0);
    src.put(8'h80, 9'h180, 8'h00, 1'b0);
    rd("flags3", OFS_FLAGS3, 8'h3F);
    wb(OFS_FLAGS3, 1'b1, 8'h00);
    rd("flags3 clr", OFS_FLAGS3, 8'h30);
    src.put(8'h80, 9'h13F, 8'h00, 1'b0);
    src.put(8'h80, 9'h000, 8'h00, 1'b0);
    rd("flags3 pwm", OFS_FLAGS3, 8'h00);
    // enables, unimplemented bits, unmapped place
    wb(OFS_ENABLE1, 1'b1, 8'hFF);
    wb(OFS_ENABLE2, 1'b1, 8'hFF);
    wb(OFS_ENABLE3, 1'b1, 8'hFF);
    wb(8'hFC, 1'b1, 8'hFF);
    rd("enable1", OFS_ENABLE1, 8'hFF);
    rd("enable2", OFS_ENABLE2, 8'h5F);
    rd("enable3", OFS_ENABLE3, 8'h3F);
    rd("unmapped", 8'hFC, 8'h00);
    // a write without its low byte select is ignored
    sel <= 4'hE;
    wb(OFS_ENABLE1, 1'b1, 8'h00);
    sel <= 4'hF;
    rd("enable1 sel", OFS_ENABLE1, 8'hFF);
    // request outputs
    src.put(8'h84, 9'h000, 8'h00, 1'b0);
    src.put(8'h80, 9'h000, 8'h00, 1'b0);
    rd("status off", OFS_STATUS, 8'h00);
    wb(OFS_CONTROL, 1'b1, 8'h40);
    rd("status group", OFS_STATUS, 8'h02);
    wb(OFS_ENABLE2, 1'b1, 8'h5D);
    rd("status masked", OFS_STATUS, 8'h00);
    wb(OFS_FLAGS2, 1'b1, 8'h00);
    src.put(8'h80, 9'h000, 8'h81, 1'b0);
    wb(OFS_PRIORITY1, 1'b1, 8'hFE);
    rd("status single", OFS_STATUS, 8'h02);
    wb(OFS_CONTROL, 1'b1, 8'h80);
    rd("status low", OFS_STATUS, 8'h01);
    wb(OFS_PRIORITY1, 1'b1, 8'hFF);
    rd("status high", OFS_STATUS, 8'h02);
    chk("irq pins", 32'h0000_0002, {30'h0000_0000, irq_high_o, irq_low_o});
    src.put(8'h80, 9'h000, 8'h80, 1'b0);
    rd("status pp off", OFS_STATUS, 8'h00);
    src.put(8'h80, 9'h000, 8'h80, 1'b1);
    rd("status pp on", OFS_STATUS, 8'h02);
    // second reset with the comparator input held high: no false change
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("flags2 rst", OFS_FLAGS2, 8'h00);
    rd("status rst", OFS_STATUS, 8'h00);
    chk("irq rst", 32'h0000_0000, {30'h0000_0000, irq_high_o, irq_low_o});
    final_report;
  end
endmodule : peripheral_irq_flag_enable_priority_tb
`default_nettype wire
